// [include/fcm_defs.vh]
// Constants for the FLL clock mode control block
`ifndef FCM_DEFS_VH
`define FCM_DEFS_VH

`define FCM_ADDR_W        3
`define FCM_OFF_C1        3'h0
`define FCM_OFF_C2        3'h1
`define FCM_OFF_C3        3'h2
`define FCM_OFF_C4        3'h3
`define FCM_OFF_STATUS    3'h4

`define FCM_C1_RST        8'h04
`define FCM_C2_RST        8'h20
`define FCM_C3_RST        8'h80
`define FCM_C4_RST        8'h00

`define FCM_BIT_LOSS      7
`define FCM_BIT_LOCK      6
`define FCM_BIT_REFST     4
`define FCM_BIT_MODE_HI   3
`define FCM_BIT_MODE_LO   2

`define FCM_SEL_FLL       2'b00
`define FCM_SEL_INT       2'b01
`define FCM_SEL_EXT       2'b10

`define FCM_FLL_MULT      11'd1280
`define FCM_LOCK_CYC      8'd64
`define FCM_CLK_MHZ       125
`define FCM_SWITCH_NS     24
`define FCM_SWITCH_CYC    ((`FCM_SWITCH_NS * `FCM_CLK_MHZ + 999) / 1000)

`endif

// [rtl/fcm_clock_mode_control.v]
// FLL clock source selection, lock status and bus divider
`timescale 1ns/1ps
`default_nettype none
`include "fcm_defs.vh"

// Functional notes
// [RULE1] Set loss flag when locked FLL leaves window
// [RULE2] Loss flag bit 7 cleared by reset or write-one
// [RULE3] Interrupt while loss flag and enable set
// [RULE4] Lock bit 6; detection off when FLL disabled
// [RULE5] Reference/divider/trim change clears lock status; a trim change here clears it only while int_mode is set
// [RULE6] Stop entry clears lock status
// [RULE7] Bit 4 shows reference in use, delayed
// [RULE8] Bits 3:2 show active output source
// [RULE9] Reserved status bits read zero
// [RULE10] Reset mode is FLL engaged internal
// [RULE11] FLL target is 1280 times reference
// [RULE12] Engaged external needs divided ref in range
// [RULE13] Internal bypass keeps FLL running
// [RULE14] Internal bypass low power disables FLL
// [RULE15] External bypass keeps FLL running
// [RULE16] External bypass low power disables FLL
// [RULE17] Stop freezes clocks except enabled internal ref
// [RULE18] Stop resets oscillator, lock reacquired later
// [RULE19] Reference select anytime; relock after switch
// [RULE20] Clock select anytime; unavailable keeps previous
// [RULE21] Software waits reference status before select
// [RULE22] Bus divider write takes effect immediately
// [RULE23] Low power disables FLL in bypass unless debug
// [RULE24] Bus divider divides by two to power
// [RULE25] Status fields come from synchronised switch
module fcm_clock_mode_control (
	input  wire                    clk_sys,
	input  wire                    rst_n,
	input  wire [`FCM_ADDR_W-1:0]  reg_addr,
	input  wire [7:0]              reg_wdata,
	input  wire                    reg_wr,
	input  wire                    reg_rd,
	output reg  [7:0]              reg_rdata,
	input  wire                    stop_req,
	input  wire                    debug_active,
	input  wire                    ext_ref_ready,
	input  wire                    freq_in_window,
	input  wire                    freq_in_lock_range,
	output reg                     lock_loss_irq,
	output reg                     fll_enable,
	output reg                     int_ref_enable,
	output reg                     ext_ref_enable,
	output reg  [1:0]              output_clock_mux,
	output reg                     ref_source_mux,
	output reg  [2:0]              bus_clock_divider,
	output reg                     output_clock_gate,
	output reg                     int_ref_clock_output_gate,
	output reg                     osc_reset,
	output reg  [10:0]             fll_multiplier
);

	////////////////////////////////////////////////////////////////
	// Control registers
	reg  [1:0] output_clock_select;
	reg        ref_source_select;
	reg  [2:0] ext_ref_divider;
	reg        int_ref_clock_enable;
	reg        int_ref_stop_enable;
	reg        low_power_select;
	reg  [7:0] trim_value;
	reg        fine_trim;
	reg        lock_loss_irq_enable;
	reg        clock_monitor_enable;

	reg        lock_loss_flag;
	reg        lock_status;
	reg  [7:0] lock_count;
	reg        stop_d;
	reg        ref_source_status;
	reg  [1:0] clock_mode_status;
	reg  [3:0] ref_wait;
	reg  [3:0] mode_wait;

	wire wr_c1 = reg_wr && (reg_addr == `FCM_OFF_C1);
	wire wr_c2 = reg_wr && (reg_addr == `FCM_OFF_C2);
	wire wr_c3 = reg_wr && (reg_addr == `FCM_OFF_C3);
	wire wr_c4 = reg_wr && (reg_addr == `FCM_OFF_C4);
	wire wr_st = reg_wr && (reg_addr == `FCM_OFF_STATUS);

	// C1: output select, divider, reference select, enables
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			output_clock_select  <= 2'h0; // [RULE10]
			ext_ref_divider      <= 3'h0;
			ref_source_select    <= 1'b1; // [RULE10]
			int_ref_clock_enable <= 1'b1;
			int_ref_stop_enable  <= 1'b0;
		end else if (wr_c1) begin
			output_clock_select  <= reg_wdata[7:6]; // [RULE20]
			ext_ref_divider      <= reg_wdata[5:3];
			ref_source_select    <= reg_wdata[2]; // [RULE19]
			int_ref_clock_enable <= reg_wdata[1];
			int_ref_stop_enable  <= reg_wdata[0];
		end
	end

	// C2: bus divider and low-power select
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bus_clock_divider <= 3'h1; // [RULE24]
			low_power_select  <= 1'b0;
		end else if (wr_c2) begin
			bus_clock_divider <= reg_wdata[7:5]; // [RULE22] [RULE24]
			low_power_select  <= reg_wdata[4]; // [RULE23]
		end
	end

	// C3: coarse trim
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			trim_value <= `FCM_C3_RST;
		else if (wr_c3)
			trim_value <= reg_wdata;
	end

	// C4: interrupt enable, monitor enable, fine trim
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			lock_loss_irq_enable <= 1'b0;
			clock_monitor_enable <= 1'b0;
			fine_trim            <= 1'b0;
		end else if (wr_c4) begin
			lock_loss_irq_enable <= reg_wdata[7]; // [RULE3]
			clock_monitor_enable <= reg_wdata[5];
			fine_trim            <= reg_wdata[0];
		end
	end

	////////////////////////////////////////////////////////////////
	// Source switching with synchronisation delay
	wire ref_target_ok = ref_source_select || ext_ref_ready;
	wire [1:0] sel_req = output_clock_select;
	wire sel_ok = (sel_req == `FCM_SEL_FLL) || (sel_req == `FCM_SEL_INT) ||
		((sel_req == `FCM_SEL_EXT) && ext_ref_ready);

	// Reference status follows the select after the sync delay
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ref_source_status <= 1'b1;
			ref_wait          <= 4'h0;
		end else if (ref_source_status != ref_source_select && ref_target_ok) begin
			if (ref_wait == `FCM_SWITCH_CYC - 1) begin
				ref_source_status <= ref_source_select; // [RULE7] [RULE25]
				ref_wait          <= 4'h0;
			end else begin
				ref_wait <= ref_wait + 4'h1;
			end
		end else begin
			ref_wait <= 4'h0;
		end
	end

	// Mode status follows; an unavailable source is never taken
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			clock_mode_status <= `FCM_SEL_FLL;
			mode_wait         <= 4'h0;
		end else if (clock_mode_status != sel_req && sel_ok) begin
			if (mode_wait == `FCM_SWITCH_CYC - 1) begin
				clock_mode_status <= sel_req; // [RULE8] [RULE25]
				mode_wait         <= 4'h0;
			end else begin
				mode_wait <= mode_wait + 4'h1;
			end
		end else begin
			mode_wait <= 4'h0; // [RULE20]
		end
	end

	////////////////////////////////////////////////////////////////
	// FLL enable and lock detection
	wire bypass   = (clock_mode_status != `FCM_SEL_FLL);
	wire fll_on   = !stop_req && !(bypass && low_power_select && !debug_active); // [RULE13] [RULE14] [RULE15] [RULE16] [RULE23]
	wire trim_chg = (wr_c3 && reg_wdata != trim_value) ||
		(wr_c4 && reg_wdata[0] != fine_trim);
	wire int_mode = ref_source_status && (clock_mode_status != `FCM_SEL_EXT);
	wire ref_chg     = wr_c1 && (reg_wdata[2] != ref_source_select);
	wire div_chg     = wr_c1 && (reg_wdata[5:3] != ext_ref_divider);
	wire switch_done = (ref_wait == `FCM_SWITCH_CYC - 1);
	wire unlock_evt  = ref_chg || div_chg || (trim_chg && int_mode) || switch_done; // [RULE5] [RULE19]
	wire stop_entry = stop_req && !stop_d;
	wire lost = lock_status && fll_on && !freq_in_window; // [RULE1]

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			stop_d <= 1'b0;
		end else begin
			stop_d <= stop_req;
		end
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			lock_status <= 1'b0;
			lock_count  <= 8'h0;
		end else if (!fll_on || stop_entry || unlock_evt || lost) begin
			lock_status <= 1'b0; // [RULE4] [RULE5] [RULE6] [RULE18]
			lock_count  <= 8'h0;
		end else if (!lock_status && freq_in_lock_range) begin
			if (lock_count == `FCM_LOCK_CYC - 8'd1) begin
				lock_status <= 1'b1; // [RULE4]
			end else begin
				lock_count <= lock_count + 8'h1;
			end
		end else if (!lock_status) begin
			lock_count <= 8'h0;
		end
	end

	////////////////////////////////////////////////////////////////
	// Loss-of-lock flag: set wins over the write-one clear
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			lock_loss_flag <= 1'b0;
		end else if (lost) begin
			lock_loss_flag <= 1'b1; // [RULE1]
		end else if (wr_st && reg_wdata[`FCM_BIT_LOSS]) begin
			lock_loss_flag <= 1'b0; // [RULE2]
		end
	end

	////////////////////////////////////////////////////////////////
	// Registered outputs
	// Interrupt request follows the flag and its enable
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			lock_loss_irq <= 1'b0;
		end else begin
			lock_loss_irq <= lock_loss_flag && lock_loss_irq_enable; // [RULE3]
		end
	end

	// FLL run request
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			fll_enable <= 1'b0;
		end else begin
			fll_enable <= fll_on; // [RULE13] [RULE14] [RULE23]
		end
	end

	// Internal reference kept on while the FLL reference or the output mux uses it
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			int_ref_enable <= 1'b1;
		end else begin
			int_ref_enable <= ref_source_status ||
				(clock_mode_status == `FCM_SEL_INT); // [RULE14]
		end
	end

	// External reference kept on while any path uses it
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ext_ref_enable <= 1'b0;
		end else begin
			ext_ref_enable <= !ref_source_status ||
				(clock_mode_status == `FCM_SEL_EXT); // [RULE12] [RULE16]
		end
	end

	// Output multiplexer follows the completed switch
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			output_clock_mux <= `FCM_SEL_FLL;
		end else begin
			output_clock_mux <= clock_mode_status; // [RULE8]
		end
	end

	// Reference multiplexer follows the completed switch
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ref_source_mux <= 1'b1;
		end else begin
			ref_source_mux <= ref_source_status; // [RULE7]
		end
	end

	// Output clock frozen in Stop
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			output_clock_gate <= 1'b0;
		end else begin
			output_clock_gate <= !stop_req; // [RULE17]
		end
	end

	// Internal reference output may run on in Stop
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			int_ref_clock_output_gate <= 1'b0;
		end else begin
			int_ref_clock_output_gate <= int_ref_clock_enable &&
				(!stop_req || int_ref_stop_enable); // [RULE17]
		end
	end

	// One-cycle oscillator reset on Stop entry
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			osc_reset <= 1'b0;
		end else begin
			osc_reset <= stop_entry; // [RULE18]
		end
	end

	// Fixed loop multiplication factor
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			fll_multiplier <= 11'h000;
		end else begin
			fll_multiplier <= `FCM_FLL_MULT; // [RULE11]
		end
	end

	////////////////////////////////////////////////////////////////
	// Read port: data stand one cycle after the strobe
	reg  [7:0] next_rdata;

	always @* begin
		next_rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
			`FCM_OFF_C1: begin
				next_rdata[7:6] = output_clock_select;
				next_rdata[5:3] = ext_ref_divider;
				next_rdata[2]   = ref_source_select;
				next_rdata[1]   = int_ref_clock_enable;
				next_rdata[0]   = int_ref_stop_enable;
			end
			`FCM_OFF_C2: begin
				next_rdata[7:5] = bus_clock_divider;
				next_rdata[4]   = low_power_select;
			end
			`FCM_OFF_C3: begin
				next_rdata = trim_value;
			end
			`FCM_OFF_C4: begin
				next_rdata[7] = lock_loss_irq_enable;
				next_rdata[5] = clock_monitor_enable;
				next_rdata[0] = fine_trim;
			end
			`FCM_OFF_STATUS: begin
				// Bits 5 and 1:0 stay zero
				next_rdata[`FCM_BIT_LOSS]  = lock_loss_flag; // [RULE2] [RULE9]
				next_rdata[`FCM_BIT_LOCK]  = lock_status; // [RULE4]
				next_rdata[`FCM_BIT_REFST] = ref_source_status; // [RULE7]
				next_rdata[`FCM_BIT_MODE_HI:`FCM_BIT_MODE_LO] = clock_mode_status; // [RULE8]
			end
			default: begin
				next_rdata = 8'h00;
			end
			endcase
		end
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= next_rdata;
		end
	end

endmodule // fcm_clock_mode_control
`default_nettype wire

// [verification/fcm_clock_mode_control_assertions.sv]
// Port-level assertions for the FLL clock mode control block
`timescale 1ns/1ps
`default_nettype none
`include "fcm_defs.vh"
module fcm_chk (
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic [2:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	input wire logic        stop_req,
	input wire logic [1:0]  output_clock_mux,
	input wire logic        ref_source_mux,
	input wire logic [2:0]  bus_clock_divider,
	input wire logic        output_clock_gate,
	input wire logic        osc_reset,
	input wire logic [10:0] fll_multiplier
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	AST_RSV_ZERO: assert property ($past(reg_rd) && $past(reg_addr) == `FCM_OFF_STATUS
		|-> reg_rdata[5] == 1'b0 && reg_rdata[1:0] == 2'b00) else $error("reserved status bit set");
	AST_STATUS_MUX: assert property ($past(reg_rd) && $past(reg_addr) == `FCM_OFF_STATUS
		|-> reg_rdata[3:2] == output_clock_mux && reg_rdata[4] == ref_source_mux)
		else $error("status differs from muxes");
	AST_MODE_LEGAL: assert property (output_clock_mux != 2'b11) else $error("reserved mode");
	AST_BUS_CLOCK_DIVIDER_NOW: assert property (reg_wr && reg_addr == `FCM_OFF_C2
		|=> {bus_clock_divider, 5'h00} == ($past(reg_wdata) & 8'he0)) else $error("divider not taken");
	AST_SYNC_DELAY: assert property (reg_wr && reg_addr == `FCM_OFF_C1
		|=> ($stable(output_clock_mux) && $stable(ref_source_mux))[*2]) else $error("switch too early");
	AST_STOP_GATE: assert property (stop_req |=> !output_clock_gate) else $error("clock runs in stop");
	AST_OSC_RESET: assert property ($rose(stop_req) |=> osc_reset ##1 !osc_reset)
		else $error("no oscillator reset pulse");
	AST_MULT: assert property ($past(rst_n) |-> fll_multiplier == `FCM_FLL_MULT)
		else $error("wrong multiplier");
endmodule // fcm_chk
bind fcm_clock_mode_control fcm_chk i_fcm_chk (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .stop_req, .output_clock_mux, .ref_source_mux, .bus_clock_divider, .output_clock_gate,
	.osc_reset, .fll_multiplier);
`default_nettype wire

// [verification/fcm_clock_mode_control_tb.sv]
// Register-level testbench for the FLL clock mode control block
`timescale 1ns/1ps
`default_nettype none
`include "fcm_defs.vh"
module fcm_clock_mode_control_tb;
	logic        clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, stop_req = 0, debug_active = 0;
	logic        ext_ref_ready = 0, freq_in_window = 1, freq_in_lock_range = 0;
	logic [2:0]  reg_addr = 0, bus_clock_divider;
	logic [7:0]  reg_wdata = 0, reg_rdata;
	logic [1:0]  output_clock_mux;
	logic [10:0] fll_multiplier;
	logic        lock_loss_irq, fll_enable, int_ref_enable, ext_ref_enable, ref_source_mux;
	logic        output_clock_gate, int_ref_clock_output_gate, osc_reset;
	int          errors = 0, num_checks = 0;
	always #4 clk_sys = ~clk_sys;
	fcm_clock_mode_control i_fcm_clock_mode_control (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .stop_req, .debug_active, .ext_ref_ready, .freq_in_window, .freq_in_lock_range,
		.lock_loss_irq, .fll_enable, .int_ref_enable, .ext_ref_enable, .output_clock_mux, .ref_source_mux,
		.bus_clock_divider, .output_clock_gate, .int_ref_clock_output_gate, .osc_reset, .fll_multiplier);
	task automatic chk(string n, logic [10:0] s, logic [10:0] e);
		num_checks++;
		if (s !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(logic [2:0] a, logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(logic [2:0] a, logic [7:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		chk("rdata", reg_rdata, e);
	endtask
	task automatic wt(int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic final_report;
		if (errors == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		errors++;
		final_report();
	end
	initial begin
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd(`FCM_OFF_STATUS, 8'h10);
		rd(`FCM_OFF_C2, 8'h20);
		rd(3'h5, 8'h00);
		chk("mult", fll_multiplier, 11'd1280);
		wr(`FCM_OFF_C1, 8'h44);
		wt(5);
		rd(`FCM_OFF_STATUS, 8'h14);
		chk("fll_en", fll_enable, 1);
		wr(`FCM_OFF_C2, 8'h30);
		wt(5);
		chk("fll_en", fll_enable, 0);
		chk("int_en", int_ref_enable, 1);
		@(posedge clk_sys) debug_active <= 1'b1;
		wt(3);
		chk("fll_en", fll_enable, 1);
		@(posedge clk_sys) debug_active <= 1'b0;
		wr(`FCM_OFF_C1, 8'h80);
		wt(5);
		rd(`FCM_OFF_STATUS, 8'h14);
		@(posedge clk_sys) ext_ref_ready <= 1'b1;
		wr(`FCM_OFF_C1, 8'h80);
		wt(5);
		rd(`FCM_OFF_STATUS, 8'h08);
		chk("fll_en", fll_enable, 0);
		chk("ext_en", ext_ref_enable, 1);
		wr(`FCM_OFF_C2, 8'h20);
		wt(3);
		chk("fll_en", fll_enable, 1);
		wr(`FCM_OFF_C1, 8'h84);
		wt(5);
		rd(`FCM_OFF_STATUS, 8'h18);
		wr(`FCM_OFF_C1, 8'h07);
		wt(5);
		rd(`FCM_OFF_STATUS, 8'h10);
		for (int i = 0; i < 8; i++) begin
			wr(`FCM_OFF_C2, {i[2:0], 5'h00});
			wt(1);
			chk("bus_clock_divider", bus_clock_divider, i[2:0]);
		end
		@(posedge clk_sys) freq_in_lock_range <= 1'b1;
		wt(70);
		rd(`FCM_OFF_STATUS, 8'h50);
		wr(`FCM_OFF_C1, 8'h0f);
		rd(`FCM_OFF_STATUS, 8'h10);
		wt(70);
		@(posedge clk_sys) stop_req <= 1'b1;
		wt(3);
		chk("gate", output_clock_gate, 0);
		chk("irgate", int_ref_clock_output_gate, 1);
		rd(`FCM_OFF_STATUS, 8'h10);
		@(posedge clk_sys) stop_req <= 1'b0;
		wt(70);
		rd(`FCM_OFF_STATUS, 8'h50);
		@(posedge clk_sys) freq_in_window <= 1'b0;
		wt(3);
		rd(`FCM_OFF_STATUS, 8'h90);
		chk("irq", lock_loss_irq, 0);
		wr(`FCM_OFF_C4, 8'h80);
		wt(2);
		chk("irq", lock_loss_irq, 1);
		wr(`FCM_OFF_STATUS, 8'h00);
		rd(`FCM_OFF_STATUS, 8'h90);
		wr(`FCM_OFF_STATUS, 8'h80);
		rd(`FCM_OFF_STATUS, 8'h10);
		chk("irq", lock_loss_irq, 0);
		final_report();
	end
endmodule // fcm_clock_mode_control_tb
`default_nettype wire
